// ### hw/dhs_sync_top.sv
/*
  Detector hit synchronizer: gated capture of hit edges, crossing alignment, crossing delay,
  occupancy histogram FIFO, test pattern source and checker, AXI4-Lite register slave.
  Assumes hit and bunch clock inputs are synchronous to core_clk and the bunch clock period spans
  at least three core_clk cycles.
*/
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "dhs_cfg.svh"

// What this block does
// - Hit outputs, checker, FIFO fill and settings advance on crossing boundaries taken from the bunch clock.
// - Each channel has one sampling gate inside every crossing period.
// - Gate width and phase programmable 0 to 25 ns in 1 ns steps.
// - A hit edge inside the gate yields one aligned pulse one crossing long.
// - The aligned pulse is delayed by zero to three whole crossings.
// - Gate sets clock phase; the delay line sets crossing alignment.
// - A 16 bit, 128 deep FIFO collects per-channel occupancy.
// - In FILL_EVERY mode the FIFO fills on every crossing until full; after that each crossing sets overflow instead.
// - In FILL_SELECT mode the FIFO fills with captured hits on the crossing whose bxCount equals selBx.
// - A pattern source feeds the channels and a checker counts mismatches.
// - Capture plus delay stays within eight crossings of latency.

module dhs_sync_top
  import dhs_pkg::*;
(
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                resetn,
  // Timing receiver and detector side
  input  wire logic                bunchClock,
  input  wire logic [`DHS_NCH-1:0] hitIn,
  output logic      [`DHS_NCH-1:0] hitOut,
  // AXI4-Lite write channels
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output logic      [1:0]          s_axi_bresp,
  // AXI4-Lite read channels
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  input  wire logic [7:0]          s_axi_araddr,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic      [31:0]         s_axi_rdata,
  output logic      [1:0]          s_axi_rresp
);

  // ==========================================================
  // Functions

  // Gate test in nanoseconds against the position of a core cycle within the crossing.
  function automatic logic gateOpen(input logic [3:0] t, input logic [4:0] ph, input logic [4:0] wd);
    logic [7:0] pos;
    pos = 8'(t) * `DHS_CLK_PERIOD_NS;
    return (pos >= 8'(ph)) && (pos < 8'(ph) + 8'(wd));
  endfunction

  function automatic logic [4:0] clampNs(input logic [4:0] v);
    return (v > `DHS_GATE_MAX_NS) ? `DHS_GATE_MAX_NS : v;
  endfunction

  function automatic logic [15:0] lfsrStep(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic isMapped(input logic [7:0] a);
    return (a[7:6] == `DHS_CHAN_PAGE) || (a <= `DHS_OFF_BXCNT);
  endfunction

  function automatic logic [31:0] regValue(input dhs_state_t s, input logic [7:0] a,
                                           input logic [15:0] memData);
    logic [31:0] v;
    logic [3:0]  ch;
    v  = '0;
    ch = a[5:2];
    if (a[7:6] == `DHS_CHAN_PAGE) begin
      v[`DHS_CH_WIDTH_LSB +: 5] = s.shWidth[ch];
      v[`DHS_CH_PHASE_LSB +: 5] = s.shPhase[ch];
      v[`DHS_CH_DELAY_LSB +: 2] = s.shDelay[ch];
    end else begin
      case (a)
        `DHS_OFF_CTRL: begin
          v[`DHS_CTRL_FILL_LSB +: 2] = s.fillMode;
          v[`DHS_CTRL_TEST_BIT]      = s.testEn;
        end
        `DHS_OFF_STATUS: begin
          v[`DHS_ST_EMPTY_BIT]          = (s.count == 8'h00);
          v[`DHS_ST_FULL_BIT]           = (s.count == `DHS_HIST_FULL);
          v[`DHS_ST_OVF_BIT]            = s.overflow;
          v[`DHS_ST_COUNT_LSB +: 8]     = s.count;
        end
        `DHS_OFF_HIST:  v[15:0] = memData;
        `DHS_OFF_SELBX: v[11:0] = s.selBx;
        `DHS_OFF_MASK:  v[15:0] = s.histMask;
        `DHS_OFF_SEED:  v[15:0] = s.patCur;
        `DHS_OFF_ERR:   v[15:0] = s.errCount;
        `DHS_OFF_BXCNT: v[11:0] = s.bxCount;
        default:        v = '0;
      endcase
    end
    return v;
  endfunction

  // ==========================================================
  // State and memory

  dhs_state_t sReg;
  dhs_state_t sNext;
  dhs_mem_if  memBus ();

  dhs_hist_mem uHistMem (
    .core_clk (core_clk),
    .resetn   (resetn),
    .m        (memBus.mem)
  );

  assign memBus.we     = sReg.memWe;
  assign memBus.wrAddr = sReg.wrPtr;
  assign memBus.wrData = sReg.memWrData;
  assign memBus.rdAddr = sReg.rdPtr;

  // ==========================================================
  // Next state

  always_comb begin
    logic                strobe;
    logic [`DHS_NCH-1:0] stim;
    logic [`DHS_NCH-1:0] hits;
    logic [`DHS_NCH-1:0] captured;
    logic [31:0]         wv;
    logic [3:0]          ch;
    logic                pop;
    logic                fill;
    logic                errClr;
    logic                ovfClr;
    strobe   = 1'b0;
    stim     = '0;
    hits     = '0;
    captured = '0;
    wv       = '0;
    ch       = '0;
    pop      = 1'b0;
    fill     = 1'b0;
    errClr   = 1'b0;
    ovfClr   = 1'b0;
    sNext    = sReg;

    // ----- Register slave -----
    case (sReg.st)
      ST_IDLE: begin
        if (s_axi_awvalid && sReg.awready) begin
          sNext.awGot  = 1'b1;
          sNext.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && sReg.wready) begin
          sNext.wGot  = 1'b1;
          sNext.wData = s_axi_wdata;
          sNext.wStrb = s_axi_wstrb;
        end
        if (s_axi_arvalid && sReg.arready) begin
          sNext.arAddr  = s_axi_araddr;
          sNext.rdEmpty = (sReg.count == 8'h00);
          sNext.st      = ST_RWAIT;
        end else if (sNext.awGot && sNext.wGot) begin
          wv = mergeBytes(regValue(sReg, sNext.awAddr, memBus.rdData), sNext.wData, sNext.wStrb);
          ch = sNext.awAddr[5:2];
          if (sNext.awAddr[7:6] == `DHS_CHAN_PAGE) begin
            sNext.shWidth[ch] = clampNs(wv[`DHS_CH_WIDTH_LSB +: 5]);
            sNext.shPhase[ch] = clampNs(wv[`DHS_CH_PHASE_LSB +: 5]);
            sNext.shDelay[ch] = wv[`DHS_CH_DELAY_LSB +: 2];
          end else begin
            case (sNext.awAddr)
              `DHS_OFF_CTRL: begin
                sNext.fillMode = dhs_fill_t'(wv[`DHS_CTRL_FILL_LSB +: 2]);
                sNext.testEn   = wv[`DHS_CTRL_TEST_BIT];
              end
              `DHS_OFF_STATUS: ovfClr = wv[`DHS_ST_OVF_BIT];
              `DHS_OFF_SELBX:  sNext.selBx = wv[11:0];
              `DHS_OFF_MASK:   sNext.histMask = wv[15:0];
              `DHS_OFF_SEED:   sNext.patCur = wv[15:0];
              `DHS_OFF_ERR:    errClr = 1'b1;
              default:         errClr = 1'b0;
            endcase
          end
          sNext.bresp  = isMapped(sNext.awAddr) ? 2'h0 : 2'h2;
          sNext.bvalid = 1'b1;
          sNext.awGot  = 1'b0;
          sNext.wGot   = 1'b0;
          sNext.st     = ST_BRESP;
        end
      end
      ST_RWAIT: begin
        sNext.rdata  = regValue(sReg, sReg.arAddr, sReg.rdEmpty ? 16'h0000 : memBus.rdData);
        sNext.rresp  = isMapped(sReg.arAddr) ? 2'h0 : 2'h2;
        sNext.rvalid = 1'b1;
        pop          = (sReg.arAddr == `DHS_OFF_HIST) && !sReg.rdEmpty;
        sNext.st     = ST_RDATA;
      end
      ST_RDATA: begin
        if (s_axi_rready) begin
          sNext.rvalid = 1'b0;
          sNext.st     = ST_IDLE;
        end
      end
      ST_BRESP: begin
        if (s_axi_bready) begin
          sNext.bvalid = 1'b0;
          sNext.st     = ST_IDLE;
        end
      end
      default: sNext.st = ST_IDLE;
    endcase
    sNext.awready = (sNext.st == ST_IDLE) && !sNext.awGot;
    sNext.wready  = (sNext.st == ST_IDLE) && !sNext.wGot;
    sNext.arready = (sNext.st == ST_IDLE) && !sNext.awGot && !sNext.wGot;

    // ----- Crossing timing -----
    strobe          = bunchClock && !sReg.bunchPrev;
    sNext.bunchPrev = bunchClock;
    if (strobe) begin
      sNext.tick    = 4'h0;
      sNext.bxCount = sReg.bxCount + 12'h001;
    end else if (sReg.tick != 4'hF) begin
      sNext.tick = sReg.tick + 4'h1;
    end

    // ----- Gated edge capture -----
    // Injected test hits are one-cycle pulses at the first gate cycle, so they always make an edge.
    for (int i = 0; i < `DHS_NCH; i++) begin
      if (sReg.actTest) begin
        stim[i] = sReg.patCur[i] && gateOpen(sReg.tick, sReg.actPhase[i], sReg.actWidth[i]) &&
                  ((sReg.tick == 4'h0) ||
                   !gateOpen(sReg.tick - 4'h1, sReg.actPhase[i], sReg.actWidth[i]));
      end else begin
        stim[i] = hitIn[i];
      end
      hits[i] = stim[i] && !sReg.hitPrev[i] &&
                gateOpen(sReg.tick, sReg.actPhase[i], sReg.actWidth[i]);
    end
    sNext.hitPrev = stim;
    captured      = sReg.pending | hits;
    sNext.pending = strobe ? '0 : captured;

    // ----- Crossing boundary: align, delay, check, configure -----
    sNext.memWe = 1'b0;
    if (strobe) begin
      sNext.dlyLine = {sReg.dlyLine[2:0], captured};
      sNext.patHist = {sReg.patHist[2:0], sReg.patCur};
      for (int i = 0; i < `DHS_NCH; i++) begin
        sNext.hitOut[i] = sNext.dlyLine[sReg.actDelay[i]][i];
        sNext.expOut[i] = sNext.patHist[sReg.actDelay[i]][i];
      end
      if (sReg.actTest) begin
        sNext.patCur = lfsrStep(sReg.patCur);
        if (sReg.chkFill != `DHS_CHECK_ARM) begin
          sNext.chkFill = sReg.chkFill + 3'h1;
        end else if ((sReg.hitOut != sReg.expOut) && (sReg.errCount != 16'hFFFF)) begin
          sNext.errCount = sReg.errCount + 16'h0001;
        end
      end else begin
        sNext.chkFill = 3'h0;
      end
      fill = (sReg.actFill == FILL_EVERY) ||
             ((sReg.actFill == FILL_SELECT) && (sReg.bxCount == sReg.selBx));
      if (fill) begin
        if (sReg.count == `DHS_HIST_FULL) begin
          sNext.overflow = 1'b1;
        end else begin
          sNext.memWe     = 1'b1;
          sNext.memWrData = captured & sReg.actMask;
        end
      end
      sNext.actWidth = sReg.shWidth;
      sNext.actPhase = sReg.shPhase;
      sNext.actDelay = sReg.shDelay;
      sNext.actFill  = sReg.fillMode;
      sNext.actTest  = sReg.testEn;
      sNext.actMask  = sReg.histMask;
    end

    // A new event beats a software clear in the same cycle.
    if (errClr && !(strobe && (sNext.errCount != sReg.errCount))) begin
      sNext.errCount = 16'h0000;
    end
    if (ovfClr && !(fill && !sNext.memWe)) begin
      sNext.overflow = 1'b0;
    end

    // ----- FIFO pointers -----
    if (sReg.memWe) begin
      sNext.wrPtr = sReg.wrPtr + 7'h01;
    end
    if (pop) begin
      sNext.rdPtr = sReg.rdPtr + 7'h01;
    end
    sNext.count = sReg.count + 8'(sReg.memWe) - 8'(pop);
  end

  // ==========================================================
  // State register

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sReg          <= '0;
      sReg.st       <= ST_IDLE;
      sReg.fillMode <= FILL_OFF;
      sReg.actFill  <= FILL_OFF;
      sReg.selBx    <= `DHS_RST_SELBX;
      sReg.histMask <= `DHS_RST_MASK;
      sReg.actMask  <= `DHS_RST_MASK;
      sReg.patCur   <= `DHS_RST_SEED;
      sReg.shWidth  <= {`DHS_NCH{`DHS_RST_WIDTH}};
      sReg.shPhase  <= {`DHS_NCH{`DHS_RST_PHASE}};
      sReg.shDelay  <= {`DHS_NCH{`DHS_RST_DELAY}};
      sReg.actWidth <= {`DHS_NCH{`DHS_RST_WIDTH}};
      sReg.actPhase <= {`DHS_NCH{`DHS_RST_PHASE}};
      sReg.actDelay <= {`DHS_NCH{`DHS_RST_DELAY}};
    end else begin
      sReg <= sNext;
    end
  end

  // ==========================================================
  // Outputs

  assign hitOut        = sReg.hitOut;
  assign s_axi_awready = sReg.awready;
  assign s_axi_wready  = sReg.wready;
  assign s_axi_bvalid  = sReg.bvalid;
  assign s_axi_bresp   = sReg.bresp;
  assign s_axi_arready = sReg.arready;
  assign s_axi_rvalid  = sReg.rvalid;
  assign s_axi_rdata   = sReg.rdata;
  assign s_axi_rresp   = sReg.rresp;

endmodule

// ### hw/dhs_cfg.svh
/*
  Constants of the hit synchronizer: sizes, register offsets, field positions, reset values and timing counts.
  Assumes it is included by bare name, before any use of the macros.
*/
`ifndef DHS_CFG_SVH
`define DHS_CFG_SVH

// ==========================================================
// Sizes
`define DHS_NCH           16
`define DHS_HIST_W        16
`define DHS_HIST_DEPTH    128
`define DHS_HIST_AW       7
`define DHS_HIST_FULL     8'h80

// ==========================================================
// Timing
`define DHS_CLK_PERIOD_NS 8'h04
`define DHS_GATE_MAX_NS   5'h19
`define DHS_LAT_BUDGET_BX 8
`define DHS_CHECK_ARM     3'h5

// ==========================================================
// Register offsets (byte addresses)
`define DHS_OFF_CTRL      8'h00
`define DHS_OFF_STATUS    8'h04
`define DHS_OFF_HIST      8'h08
`define DHS_OFF_SELBX     8'h0C
`define DHS_OFF_MASK      8'h10
`define DHS_OFF_SEED      8'h14
`define DHS_OFF_ERR       8'h18
`define DHS_OFF_BXCNT     8'h1C
`define DHS_CHAN_PAGE     2'h1

// ==========================================================
// Field positions
`define DHS_CTRL_FILL_LSB 0
`define DHS_CTRL_TEST_BIT 2
`define DHS_ST_EMPTY_BIT  0
`define DHS_ST_FULL_BIT   1
`define DHS_ST_OVF_BIT    2
`define DHS_ST_COUNT_LSB  8
`define DHS_CH_WIDTH_LSB  0
`define DHS_CH_PHASE_LSB  8
`define DHS_CH_DELAY_LSB  16

// ==========================================================
// Reset values
`define DHS_RST_WIDTH     5'h19
`define DHS_RST_PHASE     5'h00
`define DHS_RST_DELAY     2'h0
`define DHS_RST_SEED      16'h0001
`define DHS_RST_MASK      16'hFFFF
`define DHS_RST_SELBX     12'h000

`endif

// ### hw/dhs_pkg.sv
/*
  Types of the hit synchronizer: bus states, fill modes and the state records of both modules.
  Assumes dhs_cfg.svh is reachable by bare name.
*/
`include "dhs_cfg.svh"

package dhs_pkg;

  // ==========================================================
  // Enumerations
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_RWAIT = 2'h1,
    ST_RDATA = 2'h3,
    ST_BRESP = 2'h2
  } dhs_bus_st_t;

  typedef enum logic [1:0] {
    FILL_OFF    = 2'h0,
    FILL_EVERY  = 2'h1,
    FILL_SELECT = 2'h2
  } dhs_fill_t;

  // ==========================================================
  // State records
  typedef struct packed {
    logic [`DHS_HIST_DEPTH-1:0][`DHS_HIST_W-1:0] words;
    logic [`DHS_HIST_W-1:0]                      rdData;
  } dhs_mem_state_t;

  typedef struct packed {
    dhs_bus_st_t                st;
    logic                       awGot;
    logic                       wGot;
    logic [7:0]                 awAddr;
    logic [31:0]                wData;
    logic [3:0]                 wStrb;
    logic [7:0]                 arAddr;
    logic                       rdEmpty;
    logic                       awready;
    logic                       wready;
    logic                       arready;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    dhs_fill_t                  fillMode;
    logic                       testEn;
    logic [11:0]                selBx;
    logic [15:0]                histMask;
    logic [15:0]                errCount;
    logic                       overflow;
    logic [`DHS_NCH-1:0][4:0]   shWidth;
    logic [`DHS_NCH-1:0][4:0]   shPhase;
    logic [`DHS_NCH-1:0][1:0]   shDelay;
    logic [`DHS_NCH-1:0][4:0]   actWidth;
    logic [`DHS_NCH-1:0][4:0]   actPhase;
    logic [`DHS_NCH-1:0][1:0]   actDelay;
    dhs_fill_t                  actFill;
    logic                       actTest;
    logic [15:0]                actMask;
    logic                       bunchPrev;
    logic [3:0]                 tick;
    logic [11:0]                bxCount;
    logic [`DHS_NCH-1:0]        hitPrev;
    logic [`DHS_NCH-1:0]        pending;
    logic [3:0][`DHS_NCH-1:0]   dlyLine;
    logic [3:0][`DHS_NCH-1:0]   patHist;
    logic [`DHS_NCH-1:0]        patCur;
    logic [`DHS_NCH-1:0]        hitOut;
    logic [`DHS_NCH-1:0]        expOut;
    logic [2:0]                 chkFill;
    logic                       memWe;
    logic [`DHS_HIST_W-1:0]     memWrData;
    logic [`DHS_HIST_AW-1:0]    wrPtr;
    logic [`DHS_HIST_AW-1:0]    rdPtr;
    logic [7:0]                 count;
  } dhs_state_t;

endpackage

// ### hw/dhs_mem_if.sv
/*
  Carrier between the synchronizer and its histogram memory.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`include "dhs_cfg.svh"

interface dhs_mem_if;
  logic                    we;
  logic [`DHS_HIST_AW-1:0] wrAddr;
  logic [`DHS_HIST_W-1:0]  wrData;
  logic [`DHS_HIST_AW-1:0] rdAddr;
  logic [`DHS_HIST_W-1:0]  rdData;

  modport ctrl (output we, output wrAddr, output wrData, output rdAddr, input rdData);
  modport mem  (input we, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

// ### hw/dhs_hist_mem.sv
/*
  Histogram word store, one write port and one read port whose data come out of a register.
  Assumes the caller keeps the FIFO pointers; read data trail the address by one clock.
*/
`timescale 1ns/1ps
`include "dhs_cfg.svh"

module dhs_hist_mem
  import dhs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Memory port
  dhs_mem_if.mem   m
);

  dhs_mem_state_t memReg;
  dhs_mem_state_t memNext;

  always_comb begin
    memNext = memReg;
    if (m.we) begin
      memNext.words[m.wrAddr] = m.wrData;
    end
    memNext.rdData = memReg.words[m.rdAddr];
  end

  // Word contents are left unreset; only the read register gets a defined value.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      memReg.rdData <= '0;
    end else begin
      memReg <= memNext;
    end
  end

  assign m.rdData = memReg.rdData;

endmodule

// ### tb/dhs_sync_monitor.sv
/*
  Port checker bound to dhs_sync_top.
  Assumes one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps

module dhs_sync_monitor (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // Hit path
  input wire logic        bunchClock,
  input wire logic [15:0] hitOut,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  // ==========================================================
  // Crossing strobe as the block sees it
  logic bunchPrev_reg;
  logic stb;
  always_ff @(posedge core_clk) begin
    bunchPrev_reg <= bunchClock;
  end
  assign stb = bunchClock && !bunchPrev_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // ==========================================================
  // Properties
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_read_answer;
    !s_axi_arready && !s_axi_rvalid ##1 s_axi_rvalid;
  endsequence
  property p_hit_on_strobe;
    !$stable(hitOut) |-> $past(stb);
  endproperty
  property p_pulse_holds;
    hitOut[0] && !stb |=> hitOut[0];
  endproperty
  // A crossing is at least three cycles long.
  property p_one_per_crossing;
    $past(stb) |=> $stable(hitOut) [*2];
  endproperty
  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_read_lat;
    s_ar_taken |=> s_read_answer;
  endproperty
  property p_write_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid && !s_axi_awready;
  endproperty
  property p_ready_back;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##[0:1] (s_axi_awready && s_axi_wready);
  endproperty

  a_hit_on_strobe: assert property (p_hit_on_strobe) else $error("hitOut moved off strobe");
  a_pulse_holds: assert property (p_pulse_holds) else $error("pulse cut short");
  a_one_per_crossing: assert property (p_one_per_crossing) else $error("two updates per crossing");
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped");
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("rvalid dropped");
  a_read_lat: assert property (p_read_lat) else $error("read latency");
  a_write_resp: assert property (p_write_resp) else $error("bvalid late");
  a_ready_back: assert property (p_ready_back) else $error("readies not back");
endmodule

bind dhs_sync_top dhs_sync_monitor mon_u (
  .core_clk(core_clk), .resetn(resetn), .bunchClock(bunchClock), .hitOut(hitOut),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata)
);

// ### tb/dhs_fe_model.sv
/*
  Front-end model: six-cycle bunch clock and hits on command.
  Assumes fireMask is set as the bunch clock rises.
*/
`timescale 1ns/1ps

module dhs_fe_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Channels that fire in this crossing
  input  wire logic [15:0] fireMask,
  // Detector side
  output logic             bunchClock,
  output logic      [15:0] hitIn
);
  logic [2:0]  cnt_reg;
  logic [15:0] arm_reg;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cnt_reg <= 3'h0;
      arm_reg <= 16'h0000;
    end else begin
      cnt_reg <= (cnt_reg == 3'h5) ? 3'h0 : cnt_reg + 3'h1;
      if (cnt_reg == 3'h0) arm_reg <= fireMask;
    end
  end
  // A 24 ns crossing stands in for 25 ns: the core samples in 4 ns steps.
  assign bunchClock = (cnt_reg < 3'h3);
  // Two hit edges per armed crossing.
  assign hitIn = arm_reg & {16{cnt_reg == 3'h2 || cnt_reg == 3'h4}};
endmodule

// ### tb/detector_hit_synchronizer_bench.sv
/*
  Self-checking bench of the hit synchronizer.
  Assumes the front-end model and bound monitor.
*/
`timescale 1ns/1ps

module detector_hit_synchronizer_bench;
  logic        core_clk = 1'h0;
  logic        resetn   = 1'h0;
  logic [15:0] fireMask = 16'h0000;
  logic        bunchClock;
  logic [15:0] hitIn;
  logic [15:0] hitOut;
  logic        awvalid = 1'h0;
  logic        wvalid  = 1'h0;
  logic        bready  = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready  = 1'h0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0000_0000;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, rdv;
  int          bad_count = 0;
  int          n_tests   = 0;

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  dhs_fe_model fe_u (.core_clk(core_clk), .resetn(resetn), .fireMask(fireMask), .bunchClock(bunchClock),
    .hitIn(hitIn));
  dhs_sync_top dut_u (.core_clk(core_clk), .resetn(resetn), .bunchClock(bunchClock), .hitIn(hitIn),
    .hitOut(hitOut), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp));

  // ==========================================================
  // Shared tasks
  task automatic give_verdict();
    $display("checks %0d bad %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stall();
    chk(32'h0, 32'h1);
    give_verdict();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (++n > 40) stall();
    end while (!bvalid);
    r = bresp;
    bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'h0;
      if (++n > 40) stall();
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a, rdv, rsp);
    chk(rdv, e);
  endtask

  task automatic xwait(input int n);
    repeat (n) @(posedge bunchClock);
  endtask

  task automatic fire(input logic [15:0] m);
    @(posedge bunchClock);
    fireMask <= m;
    @(posedge core_clk);
    fireMask <= 16'h0000;
  endtask

  // The pulse must stand only in crossing d of the next five.
  task automatic seen(input int ch, input int d);
    for (int i = 0; i < 5; i++) begin
      @(posedge bunchClock);
      repeat (3) @(posedge core_clk);
      chk({31'h0, hitOut[ch]}, {31'h0, i == d});
    end
  endtask

  function automatic logic [31:0] chCfg(input logic [1:0] dly, input logic [4:0] ph, input logic [4:0] w);
    return {14'h0000, dly, 3'h0, ph, 3'h0, w};
  endfunction

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [7:0]  a [7] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h40};
    logic [31:0] e [7] = '{32'h0, 32'h1, 32'h0, 32'h0000_FFFF, 32'h1, 32'h0, 32'h19};
    for (int i = 0; i < 7; i++) rd_chk(a[i], e[i]);
    axi_wr(8'h30, 32'h1, rsp);
    chk({30'h0, rsp}, 32'h2);
    axi_rd(8'h30, rdv, rsp);
    chk({rdv[31:2], rsp}, 32'h2);
    $display("regs done");
  endtask

  task automatic t_delay();
    for (int d = 0; d < 4; d++) begin
      axi_wr(8'h40, chCfg(d[1:0], 5'h00, 5'h19), rsp);
      xwait(2);
      fire(16'h0001);
      seen(0, d);
    end
    $display("delay done");
  endtask

  task automatic t_gate();
    axi_wr(8'h44, chCfg(2'h0, 5'h14, 5'h04), rsp);
    xwait(2);
    fire(16'h0002);
    seen(1, 7);
    axi_wr(8'h44, chCfg(2'h0, 5'h08, 5'h0C), rsp);
    xwait(2);
    fire(16'h0002);
    seen(1, 0);
    $display("gate done");
  endtask

  task automatic t_fill();
    int hits = 0;
    axi_wr(8'h00, 32'h1, rsp);
    fire(16'h0004);
    xwait(140);
    axi_wr(8'h00, 32'h0, rsp);
    xwait(2);
    rd_chk(8'h04, 32'h0000_8006);
    repeat (128) begin
      axi_rd(8'h08, rdv, rsp);
      if (rdv === 32'h4) hits++;
    end
    chk(hits, 1);
    rd_chk(8'h04, 32'h5);
    axi_wr(8'h04, 32'h4, rsp);
    rd_chk(8'h04, 32'h1);
    $display("fill done");
  endtask

  task automatic t_test();
    axi_wr(8'h14, 32'h0000_00A5, rsp);
    axi_wr(8'h00, 32'h4, rsp);
    xwait(20);
    rd_chk(8'h18, 32'h0);
    axi_rd(8'h14, rdv, rsp);
    chk({31'h0, rdv === 32'h0000_00A5}, 32'h0);
    axi_wr(8'h00, 32'h0, rsp);
    $display("test done");
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'h1;
    t_regs();
    t_delay();
    t_gate();
    t_fill();
    t_test();
    give_verdict();
  end
endmodule
